// ===== sfc_map.svh
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH
// register offsets
`define SFC_ADDR_CFG1 8'h0D
`define SFC_ADDR_CFG2 8'h0E
`define SFC_ADDR_IRQ_STATUS 8'h09
// burst address window
`define SFC_ADDR_BURST_FIRST 8'h02
`define SFC_ADDR_DATA_LAST 8'h07
`define SFC_ADDR_STATUS_LAST 8'h09
// reset value and writable bits of the first register
`define SFC_CFG_RESET 8'h00
`define SFC_CFG1_WRITABLE 8'hF8
// first register fields
`define SFC_B1_FREEZE 3
`define SFC_B1_REARM 4
`define SFC_B1_THREE_WIRE 5
`define SFC_B1_I2C 6
`define SFC_B1_SPI 7
// second register fields
`define SFC_B2_WRAP 0
`define SFC_B2_FIFO_BURST 1
`define SFC_B2_SPI_TOKEN 2
`define SFC_B2_FIFO_TOKEN 3
`define SFC_B2_WRCLR 4
`define SFC_B2_STREAM 5
`define SFC_B2_TRIG_POL 6
`define SFC_B2_TRIG_EN 7
// samples per extended burst
`define SFC_FIFO_DEPTH 6'h20
`endif

// ===== sfc_pkg.sv
package sfc_pkg;
	// sniff detector state
	typedef enum logic {
		SFC_DET_ARMED = 1'b0,
		SFC_DET_HALTED = 1'b1
	} sfc_det_t;
	// selected host interface
	typedef enum logic [1:0] {
		SFC_IF_NONE = 2'h0,
		SFC_IF_I2C = 2'h1,
		SFC_IF_SPI4 = 2'h3,
		SFC_IF_SPI3 = 2'h2
	} sfc_iface_t;
endpackage : sfc_pkg

// ===== sfc_burst_addr.sv
`include "sfc_map.svh"
module sfc_burst_addr (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// transaction control
	input wire logic i_start,
	input wire logic [7:0] i_start_addr,
	input wire logic i_advance,
	// configuration
	input wire logic i_wrap_select,
	input wire logic i_fifo_burst,
	// address and fifo pop
	output logic [7:0] o_addr,
	output logic o_fifo_pop,
	output logic o_burst_limited
);
	logic [7:0] addr_q;
	logic [7:0] addr_d;
	logic [5:0] samples_q;
	logic [7:0] wrap_end;
	logic at_sample_end;

	// wrap point and next address
	assign wrap_end = i_wrap_select ? `SFC_ADDR_STATUS_LAST : `SFC_ADDR_DATA_LAST;
	assign addr_d = (addr_q == wrap_end) ? `SFC_ADDR_BURST_FIRST : 8'(addr_q + 8'h01);
	assign at_sample_end = i_advance && (addr_q == `SFC_ADDR_DATA_LAST);
	// one sample per transaction unless extended bursts are on
	assign o_fifo_pop = at_sample_end && (samples_q < `SFC_FIFO_DEPTH)
		&& (i_fifo_burst || samples_q == 6'h00);
	assign o_burst_limited = !i_fifo_burst && samples_q != 6'h00;
	assign o_addr = addr_q;

	// address counter
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			addr_q <= 8'h00;
		end else if (i_start) begin
			addr_q <= i_start_addr;
		end else if (i_advance) begin
			addr_q <= addr_d;
		end
	end

	// samples popped in this transaction
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			samples_q <= 6'h00;
		end else if (i_start) begin
			samples_q <= 6'h00;
		end else if (o_fifo_pop) begin
			samples_q <= 6'(samples_q + 6'h01);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions
	a_wrap_short: assert property (@(posedge i_clock) disable iff (!i_resetn)
		!i_start && i_advance && !i_wrap_select && addr_q == 8'h07 |=> addr_q == 8'h02)
		else $error("burst did not wrap after 0x07");
	a_wrap_long: assert property (@(posedge i_clock) disable iff (!i_resetn)
		!i_start && i_advance && i_wrap_select && addr_q == 8'h07 |=> addr_q == 8'h08)
		else $error("long wrap left status registers out");
	a_wrap_status: assert property (@(posedge i_clock) disable iff (!i_resetn)
		!i_start && i_advance && i_wrap_select && addr_q == 8'h09 |=> addr_q == 8'h02)
		else $error("burst did not wrap after 0x09");
	a_burst_six: assert property (@(posedge i_clock) disable iff (!i_resetn)
		o_fifo_pop && !i_fifo_burst |-> samples_q == 6'h00)
		else $error("second sample popped without extended bursts");
	a_burst_depth: assert property (@(posedge i_clock) disable iff (!i_resetn)
		samples_q <= 6'h20)
		else $error("more than 32 samples in one burst");
	c_long_burst: cover property (@(posedge i_clock) disable iff (!i_resetn)
		o_fifo_pop && samples_q == 6'h02);
endmodule : sfc_burst_addr

// ===== sfc_feature_regs.sv
`include "sfc_map.svh"
module sfc_feature_regs (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_resetn,
	// register access from the serial engine
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_txn_is_i2c,
	output logic [7:0] o_reg_rdata,
	// burst control
	input wire logic i_burst_start,
	input wire logic i_burst_advance,
	output logic [7:0] o_burst_addr,
	output logic o_fifo_pop,
	output logic o_burst_limited,
	// interface selection
	output sfc_pkg::sfc_iface_t o_iface_mode,
	output logic o_i2c_enable,
	output logic o_spi_enable,
	output logic o_three_wire_serial_select,
	output logic o_axis_update_en,
	// sniff detector and irq clearing
	input wire logic i_motion_wake_mode,
	input wire logic i_sniff_event,
	output logic o_irq_clear,
	output logic o_motion_wake_irq_flag,
	output logic o_detector_armed,
	// fifo capture
	input wire logic i_sample_valid,
	input wire logic i_fifo_full,
	input wire logic i_fifo_empty,
	input wire logic i_queue_threshold_flag,
	input wire logic i_irq_pending_flag,
	output logic o_fifo_capture_en,
	output logic o_fifo_discard_oldest,
	output logic o_fifo_stream,
	// status tokens
	input wire logic i_spi_first_byte,
	input wire logic i_high_res,
	input wire logic i_z_load,
	input wire logic [15:0] i_fifo_z_word,
	output logic o_spi_token_drive,
	output logic [3:0] o_spi_token,
	output logic [15:0] o_fifo_z_word,
	// external trigger settings kept for other blocks
	output logic o_ext_trig_en,
	output logic o_ext_trig_pol
);
	logic [7:0] cfg1_q;
	logic [7:0] cfg2_q;
	logic [7:0] rdata_q;
	logic [3:0] token_q;
	logic [15:0] zword_q;
	logic flag_q;
	sfc_pkg::sfc_det_t det_q;
	sfc_pkg::sfc_det_t det_d;

	////////////////////////////////////////////////////////////////////////////
	// status token insertion into a Z fifo word
	function automatic logic [15:0] sfc_token_word(input logic [15:0] z, input logic [3:0] f,
		input logic high_res);
		sfc_token_word = high_res ? {z[15:4], f} : {f, z[11:0]};
	endfunction : sfc_token_word

	////////////////////////////////////////////////////////////////////////////
	// decode
	logic hit_cfg1;
	logic hit_cfg2;
	logic hit_status;
	logic wr_cfg1;
	logic wr_cfg2;
	assign hit_cfg1 = i_reg_addr == `SFC_ADDR_CFG1;
	assign hit_cfg2 = i_reg_addr == `SFC_ADDR_CFG2;
	assign hit_status = i_reg_addr == `SFC_ADDR_IRQ_STATUS;
	assign wr_cfg1 = i_reg_wr && hit_cfg1;
	assign wr_cfg2 = i_reg_wr && hit_cfg2;

	// configuration fields
	logic sel_spi;
	logic sel_i2c;
	logic sel_three;
	logic freeze;
	logic rearm;
	logic wrclr;
	logic spi_token;
	logic fifo_token;
	assign sel_spi = cfg1_q[`SFC_B1_SPI];
	assign sel_i2c = cfg1_q[`SFC_B1_I2C];
	assign sel_three = cfg1_q[`SFC_B1_THREE_WIRE];
	assign freeze = cfg1_q[`SFC_B1_FREEZE];
	assign rearm = cfg1_q[`SFC_B1_REARM];
	assign wrclr = cfg2_q[`SFC_B2_WRCLR];
	assign spi_token = cfg2_q[`SFC_B2_SPI_TOKEN];
	assign fifo_token = cfg2_q[`SFC_B2_FIFO_TOKEN];

	////////////////////////////////////////////////////////////////////////////
	// configuration registers, low bits of the first held at zero
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg1_q <= `SFC_CFG_RESET;
			cfg2_q <= `SFC_CFG_RESET;
		end else begin
			if (wr_cfg1) begin
				cfg1_q <= i_reg_wdata & `SFC_CFG1_WRITABLE;
			end
			if (wr_cfg2) begin
				cfg2_q <= i_reg_wdata;
			end
		end
	end

	// read data, unmapped offsets read as zero
	logic [7:0] rd_mux;
	assign rd_mux = hit_cfg1 ? cfg1_q : (hit_cfg2 ? cfg2_q : 8'h00);
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_q <= 8'h00;
		end else if (i_reg_rd) begin
			rdata_q <= rd_mux;
		end
	end
	assign o_reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// interface selection
	assign o_i2c_enable = !sel_spi;
	assign o_spi_enable = !sel_i2c;
	assign o_three_wire_serial_select = sel_three;
	assign o_axis_update_en = sel_spi || sel_i2c || sel_three;
	assign o_iface_mode = sel_i2c ? sfc_pkg::SFC_IF_I2C
		: (sel_three ? sfc_pkg::SFC_IF_SPI3
		: (sel_spi ? sfc_pkg::SFC_IF_SPI4 : sfc_pkg::SFC_IF_NONE));

	////////////////////////////////////////////////////////////////////////////
	// irq clear: writes always, I2C reads unless write-clear owns it
	logic read_clears;
	assign read_clears = i_txn_is_i2c && !(wrclr && sel_i2c);
	assign o_irq_clear = hit_status && (i_reg_wr || (i_reg_rd && read_clears));

	// motion wake flag, an event beats a clear in the same cycle
	logic flag_set;
	assign flag_set = i_sniff_event && i_motion_wake_mode && det_q == sfc_pkg::SFC_DET_ARMED;
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			flag_q <= 1'b0;
		end else if (flag_set) begin
			flag_q <= 1'b1;
		end else if (o_irq_clear) begin
			flag_q <= 1'b0;
		end
	end
	assign o_motion_wake_irq_flag = flag_q;

	// sniff detector halts after its irq until cleared with rearm set, or mode exit
	always_comb begin
		det_d = det_q;
		unique case (det_q)
			sfc_pkg::SFC_DET_ARMED: begin
				if (flag_set) begin
					det_d = sfc_pkg::SFC_DET_HALTED;
				end
			end
			sfc_pkg::SFC_DET_HALTED: begin
				if (!i_motion_wake_mode || (rearm && o_irq_clear)) begin
					det_d = sfc_pkg::SFC_DET_ARMED;
				end
			end
		endcase
	end
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			det_q <= sfc_pkg::SFC_DET_ARMED;
		end else begin
			det_q <= det_d;
		end
	end
	assign o_detector_armed = det_q == sfc_pkg::SFC_DET_ARMED;

	////////////////////////////////////////////////////////////////////////////
	// fifo capture and stream discard
	assign o_fifo_capture_en = !(freeze && flag_q);
	assign o_fifo_stream = cfg2_q[`SFC_B2_STREAM];
	assign o_fifo_discard_oldest = o_fifo_stream && i_fifo_full && i_sample_valid
		&& o_fifo_capture_en;
	assign o_ext_trig_en = cfg2_q[`SFC_B2_TRIG_EN];
	assign o_ext_trig_pol = cfg2_q[`SFC_B2_TRIG_POL];

	////////////////////////////////////////////////////////////////////////////
	// status tokens
	logic [3:0] flags;
	assign flags = {i_irq_pending_flag, i_queue_threshold_flag, i_fifo_full, i_fifo_empty};
	assign o_spi_token_drive = spi_token && i_spi_first_byte && sel_spi && !sel_three
		&& !i_txn_is_i2c;
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			token_q <= 4'h0;
		end else begin
			token_q <= flags;
		end
	end
	assign o_spi_token = token_q;

	// Z fifo word with optional token
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			zword_q <= 16'h0000;
		end else if (i_z_load) begin
			zword_q <= fifo_token ? sfc_token_word(i_fifo_z_word, flags, i_high_res)
				: i_fifo_z_word;
		end
	end
	assign o_fifo_z_word = zword_q;

	////////////////////////////////////////////////////////////////////////////
	// burst address counter
	sfc_burst_addr sfc_burst_addr_inst (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_start(i_burst_start),
		.i_start_addr(i_reg_addr),
		.i_advance(i_burst_advance),
		.i_wrap_select(cfg2_q[`SFC_B2_WRAP]),
		.i_fifo_burst(cfg2_q[`SFC_B2_FIFO_BURST]),
		.o_addr(o_burst_addr),
		.o_fifo_pop(o_fifo_pop),
		.o_burst_limited(o_burst_limited)
	);

	////////////////////////////////////////////////////////////////////////////
	// assertions
	a_axis_gate: assert property (@(posedge i_clock) disable iff (!i_resetn)
		cfg1_q[7:5] == 3'h0 |-> !o_axis_update_en)
		else $error("axis update enabled with no interface");
	a_low_bits: assert property (@(posedge i_clock) disable iff (!i_resetn)
		wr_cfg1 |=> cfg1_q[2:0] == 3'h0)
		else $error("low bits of first register not zero");
	a_capture_halt: assert property (@(posedge i_clock) disable iff (!i_resetn)
		flag_set && cfg1_q[3] && !wr_cfg1 |=> !o_fifo_capture_en)
		else $error("fifo still capturing after motion wake irq");
	a_capture_run: assert property (@(posedge i_clock) disable iff (!i_resetn)
		!cfg1_q[3] |-> o_fifo_capture_en)
		else $error("fifo halted with capture-halt clear");
	a_detector_halt: assert property (@(posedge i_clock) disable iff (!i_resetn)
		flag_set ##1 (i_motion_wake_mode && !o_irq_clear) |-> !o_detector_armed)
		else $error("detector not halted after its irq");
	a_rearm_clear: assert property (@(posedge i_clock) disable iff (!i_resetn)
		!o_detector_armed && o_irq_clear && cfg1_q[4] |=> o_detector_armed)
		else $error("clear did not rearm detector");
	a_no_rearm: assert property (@(posedge i_clock) disable iff (!i_resetn)
		!o_detector_armed && i_motion_wake_mode && !cfg1_q[4] |=> !o_detector_armed)
		else $error("detector rearmed without mode exit");
	a_iface_excl: assert property (@(posedge i_clock) disable iff (!i_resetn)
		cfg1_q[6] |-> !o_spi_enable && o_three_wire_serial_select == cfg1_q[5])
		else $error("SPI open while I2C selected");
	a_spi_excl: assert property (@(posedge i_clock) disable iff (!i_resetn)
		cfg1_q[7] |-> !o_i2c_enable)
		else $error("I2C open while SPI selected");
	a_spi_clear: assert property (@(posedge i_clock) disable iff (!i_resetn)
		!i_txn_is_i2c && i_reg_rd && !i_reg_wr |-> !o_irq_clear)
		else $error("SPI read cleared interrupts");
	a_i2c_rd_clear: assert property (@(posedge i_clock) disable iff (!i_resetn)
		i_txn_is_i2c && i_reg_rd && hit_status && cfg1_q[6] |-> o_irq_clear == !cfg2_q[4])
		else $error("I2C read clear wrong for write-clear setting");
	a_wrclr_no_i2c: assert property (@(posedge i_clock) disable iff (!i_resetn)
		i_txn_is_i2c && i_reg_rd && hit_status && !cfg1_q[6] |-> o_irq_clear)
		else $error("I2C read did not clear without I2C selected");
	a_flag_set_wins: assert property (@(posedge i_clock) disable iff (!i_resetn)
		flag_set |=> o_motion_wake_irq_flag)
		else $error("motion wake event lost");
	a_token_low: assert property (@(posedge i_clock) disable iff (!i_resetn)
		i_z_load && cfg2_q[3] && !i_high_res |=> o_fifo_z_word[15:12] == $past(flags))
		else $error("token missing from top of Z word");
	a_token_high: assert property (@(posedge i_clock) disable iff (!i_resetn)
		i_z_load && cfg2_q[3] && i_high_res |=> o_fifo_z_word[3:0] == $past(flags))
		else $error("token missing from bottom of Z word");
	a_spi_token: assert property (@(posedge i_clock) disable iff (!i_resetn)
		o_spi_token_drive |-> cfg1_q[7] && !cfg1_q[5] && cfg2_q[2])
		else $error("token driven outside 4-wire SPI");
	c_rearm: cover property (@(posedge i_clock) disable iff (!i_resetn)
		!o_detector_armed ##1 o_detector_armed);
	c_wrclr: cover property (@(posedge i_clock) disable iff (!i_resetn)
		o_irq_clear && i_reg_wr && i_txn_is_i2c);
	c_discard: cover property (@(posedge i_clock) disable iff (!i_resetn)
		o_fifo_discard_oldest);
endmodule : sfc_feature_regs

// ===== sfc_host_model.sv
`include "sfc_map.svh"
module sfc_host_model (
	// clock
	input wire logic i_clock,
	// requests toward the block
	output logic o_reg_wr,
	output logic o_reg_rd,
	output logic [7:0] o_reg_addr,
	output logic [7:0] o_reg_wdata,
	output logic o_txn_is_i2c,
	output logic o_burst_start,
	output logic o_burst_advance,
	// answers from the block
	input wire logic [7:0] i_reg_rdata,
	input wire logic i_irq_clear,
	input wire logic i_fifo_pop
);
	timeunit 1ns;
	timeprecision 1ns;
	logic seen_clear;
	logic seen_pop;
	logic [7:0] seen_data;
	initial begin
		{o_reg_wr, o_reg_rd, o_burst_start, o_burst_advance} = 4'h0;
		o_reg_addr = 8'h00;
		o_reg_wdata = 8'h00;
		o_txn_is_i2c = 1'b1;
	end
	// one access: kind bits are write, read, burst start, burst advance
	task cyc(input logic [3:0] kind, input logic [7:0] addr, input logic [7:0] data,
		input logic i2c);
		@(posedge i_clock);
		{o_burst_advance, o_burst_start, o_reg_rd, o_reg_wr} <= kind;
		o_reg_addr <= addr;
		// reserved low bits of the first register always go out as zero
		o_reg_wdata <= (addr == `SFC_ADDR_CFG1) ? (data & `SFC_CFG1_WRITABLE) : data;
		o_txn_is_i2c <= i2c;
		// comb answers stand only in the access cycle
		@(negedge i_clock);
		seen_clear = i_irq_clear;
		seen_pop = i_fifo_pop;
		@(posedge i_clock);
		{o_burst_advance, o_burst_start, o_reg_rd, o_reg_wr} <= 4'h0;
		// released lines are scrambled so stale values never look live
		o_reg_addr <= ~addr;
		o_reg_wdata <= ~data;
		@(negedge i_clock);
		seen_data = i_reg_rdata;
	endtask : cyc
endmodule : sfc_host_model

// ===== sensor_feature_config_regs_bench.sv
`include "sfc_map.svh"
module sensor_feature_config_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clock = 1'b0;
	logic i_resetn = 1'b0;
	logic wr, rd, i2c, bs, ba, clr, pop, lim, wake, evt, sv, full, empty, th, pend, fb, hr, zl;
	logic [7:0] addr, wdata, rdata, baddr;
	logic [15:0] zw = 16'h1234;
	logic [15:0] z_axis_output;
	int n_fail = 0;
	int n_tests = 0;
	int cycles = 0;
	initial {wake, evt, sv, full, empty, th, pend, fb, hr, zl} = 10'h000;
	always #50 i_clock = ~i_clock;
	////////////////////////////////////////////////////////////////
	sfc_host_model sfc_host_model_inst (.i_clock(i_clock), .o_reg_wr(wr), .o_reg_rd(rd),
		.o_reg_addr(addr), .o_reg_wdata(wdata), .o_txn_is_i2c(i2c), .o_burst_start(bs),
		.o_burst_advance(ba), .i_reg_rdata(rdata), .i_irq_clear(clr), .i_fifo_pop(pop));
	sfc_feature_regs sfc_feature_regs_inst (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_txn_is_i2c(i2c), .o_reg_rdata(rdata), .i_burst_start(bs), .i_burst_advance(ba),
		.o_burst_addr(baddr), .o_fifo_pop(pop), .o_burst_limited(lim), .o_iface_mode(),
		.o_i2c_enable(), .o_spi_enable(), .o_three_wire_serial_select(), .o_axis_update_en(),
		.i_motion_wake_mode(wake), .i_sniff_event(evt), .o_irq_clear(clr),
		.o_motion_wake_irq_flag(), .o_detector_armed(), .i_sample_valid(sv),
		.i_fifo_full(full), .i_fifo_empty(empty), .i_queue_threshold_flag(th),
		.i_irq_pending_flag(pend), .o_fifo_capture_en(), .o_fifo_discard_oldest(),
		.o_fifo_stream(), .i_spi_first_byte(fb), .i_high_res(hr), .i_z_load(zl),
		.i_fifo_z_word(zw), .o_spi_token_drive(), .o_spi_token(), .o_fifo_z_word(z_axis_output),
		.o_ext_trig_en(), .o_ext_trig_pol());
	////////////////////////////////////////////////////////////////
	// compare, verdict and hang guard
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task conclude;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail++;
			conclude();
		end
	end
	task acc(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d, input logic s);
		sfc_host_model_inst.cyc(k, a, d, s);
	endtask : acc
	////////////////////////////////////////////////////////////////
	// scenario helpers
	task iface(input logic [7:0] c1, input logic [1:0] m, input logic [3:0] en);
		acc(4'h1, `SFC_ADDR_CFG1, c1, 1'b1);
		check("iface_mode", sfc_feature_regs_inst.o_iface_mode, m);
		check("enables", {sfc_feature_regs_inst.o_i2c_enable, sfc_feature_regs_inst.o_spi_enable,
			sfc_feature_regs_inst.o_three_wire_serial_select,
			sfc_feature_regs_inst.o_axis_update_en}, en);
	endtask : iface
	task clr_case(input logic [7:0] c1, input logic [7:0] c2, input logic s,
		input logic [3:0] k, input logic exp);
		acc(4'h1, `SFC_ADDR_CFG1, c1, 1'b1);
		acc(4'h1, `SFC_ADDR_CFG2, c2, 1'b1);
		acc(k, `SFC_ADDR_IRQ_STATUS, 8'h5A, s);
		check("irq_clear", sfc_host_model_inst.seen_clear, exp);
	endtask : clr_case
	task burst_run(input logic [7:0] c2, input int n);
		logic [7:0] a;
		logic [7:0] last;
		logic got;
		acc(4'h1, `SFC_ADDR_CFG2, c2, 1'b1);
		acc(4'h4, `SFC_ADDR_BURST_FIRST, 8'h00, 1'b1);
		a = `SFC_ADDR_BURST_FIRST;
		got = 1'b0;
		last = c2[0] ? `SFC_ADDR_STATUS_LAST : `SFC_ADDR_DATA_LAST;
		for (int i = 0; i < n; i++) begin
			acc(4'h8, 8'h00, 8'h00, 1'b1);
			check("fifo_pop", sfc_host_model_inst.seen_pop,
				(a == 8'h07) && (!got || c2[1]));
			got = got | (a == 8'h07);
			a = (a == last) ? `SFC_ADDR_BURST_FIRST : a + 8'h01;
			check("burst_addr", baddr, a);
		end
		check("burst_limited", lim, !c2[1]);
	endtask : burst_run
	task sniff_pulse;
		@(posedge i_clock);
		wake <= 1'b1;
		evt <= 1'b1;
		@(posedge i_clock);
		evt <= 1'b0;
		@(negedge i_clock);
		check("wake_flag", sfc_feature_regs_inst.o_motion_wake_irq_flag, 1'b1);
		check("armed", sfc_feature_regs_inst.o_detector_armed, 1'b0);
	endtask : sniff_pulse
	task z_case(input logic [7:0] c2, input logic h, input logic [15:0] exp);
		acc(4'h1, `SFC_ADDR_CFG2, c2, 1'b1);
		@(posedge i_clock);
		hr <= h;
		zl <= 1'b1;
		@(posedge i_clock);
		zl <= 1'b0;
		@(negedge i_clock);
		check("z_word", z_axis_output, exp);
	endtask : z_case
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (12) @(posedge i_clock);
		i_resetn <= 1'b1;
		acc(4'h2, `SFC_ADDR_CFG1, 8'h00, 1'b1);
		check("cfg1_reset", sfc_host_model_inst.seen_data, 8'h00);
		acc(4'h2, `SFC_ADDR_CFG2, 8'h00, 1'b1);
		check("cfg2_reset", sfc_host_model_inst.seen_data, 8'h00);
		check("armed_reset", sfc_feature_regs_inst.o_detector_armed, 1'b1);
		iface(8'h00, sfc_pkg::SFC_IF_NONE, 4'hC);
		iface(8'h40, sfc_pkg::SFC_IF_I2C, 4'h9);
		iface(8'h80, sfc_pkg::SFC_IF_SPI4, 4'h5);
		iface(8'h20, sfc_pkg::SFC_IF_SPI3, 4'hF);
		acc(4'h1, `SFC_ADDR_CFG1, 8'hFF, 1'b1);
		acc(4'h2, `SFC_ADDR_CFG1, 8'h00, 1'b1);
		check("cfg1_rw", sfc_host_model_inst.seen_data, 8'hF8);
		acc(4'h1, `SFC_ADDR_CFG2, 8'hE5, 1'b1);
		acc(4'h2, `SFC_ADDR_CFG2, 8'h00, 1'b1);
		check("cfg2_rw", sfc_host_model_inst.seen_data, 8'hE5);
		check("trig_stream", {sfc_feature_regs_inst.o_ext_trig_en,
			sfc_feature_regs_inst.o_ext_trig_pol, sfc_feature_regs_inst.o_fifo_stream}, 3'h7);
		acc(4'h1, 8'h20, 8'hFF, 1'b1);
		acc(4'h2, 8'h20, 8'h00, 1'b1);
		check("unmapped", sfc_host_model_inst.seen_data, 8'h00);
		$display("registers and interface select done");
		clr_case(8'h40, 8'h00, 1'b1, 4'h2, 1'b1);
		clr_case(8'h40, 8'h10, 1'b1, 4'h2, 1'b0);
		clr_case(8'h40, 8'h10, 1'b1, 4'h1, 1'b1);
		clr_case(8'h80, 8'h10, 1'b1, 4'h2, 1'b1);
		clr_case(8'h80, 8'h00, 1'b0, 4'h2, 1'b0);
		clr_case(8'h80, 8'h10, 1'b0, 4'h1, 1'b1);
		$display("interrupt clearing done");
		burst_run(8'h00, 12);
		burst_run(8'h02, 18);
		burst_run(8'h01, 9);
		$display("burst addressing done");
		acc(4'h1, `SFC_ADDR_CFG2, 8'h20, 1'b1);
		acc(4'h1, `SFC_ADDR_CFG1, 8'h58, 1'b1);
		sniff_pulse();
		check("capture_frozen", sfc_feature_regs_inst.o_fifo_capture_en, 1'b0);
		acc(4'h1, `SFC_ADDR_IRQ_STATUS, 8'h00, 1'b1);
		check("rearm_clear", sfc_feature_regs_inst.o_detector_armed, 1'b1);
		acc(4'h1, `SFC_ADDR_CFG1, 8'h40, 1'b1);
		sniff_pulse();
		check("capture_on", sfc_feature_regs_inst.o_fifo_capture_en, 1'b1);
		@(posedge i_clock);
		{sv, full, pend, th, empty} <= 5'h1C;
		@(negedge i_clock);
		check("discard", sfc_feature_regs_inst.o_fifo_discard_oldest, 1'b1);
		@(posedge i_clock);
		sv <= 1'b0;
		acc(4'h1, `SFC_ADDR_IRQ_STATUS, 8'h00, 1'b1);
		check("no_rearm", sfc_feature_regs_inst.o_detector_armed, 1'b0);
		@(posedge i_clock);
		wake <= 1'b0;
		@(posedge i_clock);
		@(negedge i_clock);
		check("rearm_exit", sfc_feature_regs_inst.o_detector_armed, 1'b1);
		$display("sniff detector done");
		z_case(8'h08, 1'b0, 16'hA234);
		z_case(8'h08, 1'b1, 16'h123A);
		z_case(8'h00, 1'b0, 16'h1234);
		check("spi_token", sfc_feature_regs_inst.o_spi_token, 4'hA);
		acc(4'h1, `SFC_ADDR_CFG2, 8'h04, 1'b0);
		acc(4'h1, `SFC_ADDR_CFG1, 8'h80, 1'b0);
		@(posedge i_clock);
		fb <= 1'b1;
		@(negedge i_clock);
		check("token_drive", sfc_feature_regs_inst.o_spi_token_drive, 1'b1);
		acc(4'h1, `SFC_ADDR_CFG1, 8'h20, 1'b0);
		check("token_3wire", sfc_feature_regs_inst.o_spi_token_drive, 1'b0);
		$display("status tokens done");
		conclude();
	end
endmodule : sensor_feature_config_regs_bench
